// [vic_core.sv]
// Vectored interrupt control with AXI4-Lite register access
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module vic_core #(
	parameter int NSRC = vic_pkg::NUM_SRC
) (
	input  wire logic                        SYS_CLK_I,
	input  wire logic                        RST_N_I,
	// Source request pulses, bit i is vector 10+i
	input  wire logic [NSRC-1:0]             SRC_REQ_I,
	// Software trap strobe from the core, any number 0 or 32..63
	input  wire logic                        TRAP_REQ_I,
	input  wire logic [vic_pkg::VEC_W-1:0]   TRAP_NUM_I,
	// Core takes the offered vector
	input  wire logic                        CPU_ACK_I,
	output logic                             CPU_IRQ_O,
	output logic [vic_pkg::VEC_W-1:0]        CPU_VEC_O,
	output logic [vic_pkg::LVL_W-1:0]        CPU_LVL_O,
	output logic [vic_pkg::DATA_W-1:0]       CPU_VADDR_O,
	output logic                             CPU_NMASK_O,
	output logic                             IRQ_O,
	// AXI4-Lite
	input  wire logic [vic_pkg::ADDR_W-1:0]  S_AXI_AWADDR,
	input  wire logic                        S_AXI_AWVALID,
	output logic                             S_AXI_AWREADY,
	input  wire logic [vic_pkg::DATA_W-1:0]  S_AXI_WDATA,
	input  wire logic [3:0]                  S_AXI_WSTRB,
	input  wire logic                        S_AXI_WVALID,
	output logic                             S_AXI_WREADY,
	output logic [1:0]                       S_AXI_BRESP,
	output logic                             S_AXI_BVALID,
	input  wire logic                        S_AXI_BREADY,
	input  wire logic [vic_pkg::ADDR_W-1:0]  S_AXI_ARADDR,
	input  wire logic                        S_AXI_ARVALID,
	output logic                             S_AXI_ARREADY,
	output logic [vic_pkg::DATA_W-1:0]       S_AXI_RDATA,
	output logic [1:0]                       S_AXI_RRESP,
	output logic                             S_AXI_RVALID,
	input  wire logic                        S_AXI_RREADY
);
	import vic_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State

	logic                   glb_en;
	logic [LVL_W-1:0]       thr;
	logic [DATA_W-1:0]      vbase;
	logic [NSRC-1:0]        req;
	logic [LVL_W-1:0]       lvl [NSRC];
	logic [NUM_EV-1:0]      status;
	logic [NUM_EV-1:0]      mask;
	logic                   trap_pend;
	logic [VEC_W-1:0]       trap_num;
	logic [VEC_W-1:0]       last_vec;
	vic_state_t             state;
	vic_state_t             next_state;

	logic                   aw_held;
	logic                   w_held;
	logic [ADDR_W-1:0]      aw_addr;
	logic [DATA_W-1:0]      w_data;
	logic [3:0]             w_strb;

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Control slot index from byte address, NSRC when not a control word
	function automatic int ctrl_idx(input logic [ADDR_W-1:0] a);
		int r;
		r = NSRC;
		if (a >= OFF_CTRL0 && a <= OFF_CTRL_END && a[1:0] == 2'h0) begin
			r = int'((a - OFF_CTRL0) >> ENTRY_SHIFT);
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Arbitration: highest level wins, lowest vector on a tie

	logic [NSRC-1:0]        eligible;
	logic                   any_mask;
	logic [VEC_W-1:0]       best_vec;
	logic [LVL_W-1:0]       best_lvl;
	logic [$clog2(NSRC+1)-1:0] best_idx;

	always_comb begin
		any_mask = 1'b0;
		best_lvl = '0;
		best_idx = '0;
		for (int i = 0; i < NSRC; i++) begin
			// Level zero never exceeds any threshold, so it disables
			eligible[i] = glb_en && req[i] && (lvl[i] > thr);
			if (eligible[i] && (!any_mask || lvl[i] > best_lvl)) begin
				any_mask = 1'b1;
				best_lvl = lvl[i];
				best_idx = ($clog2(NSRC+1))'(i);
			end
		end
		best_vec = VEC_FIRST_HW + VEC_W'(best_idx);
	end

	// Traps bypass enable and threshold and take precedence
	wire                    trap_ok   = TRAP_REQ_I && (TRAP_NUM_I == VEC_BRK || TRAP_NUM_I >= VEC_SW_FIRST);
	wire                    offer     = trap_pend || any_mask;
	wire [VEC_W-1:0]        sel_vec   = trap_pend ? trap_num : best_vec;
	wire [LVL_W-1:0]        sel_lvl   = trap_pend ? LVL_MAX : best_lvl;
	wire                    take      = (state == VIC_WAIT) && CPU_ACK_I;
	wire [DATA_W-1:0]       sel_addr  = vbase + (DATA_W'(CPU_VEC_O) << ENTRY_SHIFT);

	always_comb begin
		case (state)
			VIC_IDLE: next_state = offer ? VIC_SEL : VIC_IDLE;
			VIC_SEL:  next_state = VIC_WAIT;
			VIC_WAIT: next_state = CPU_ACK_I ? VIC_IDLE : VIC_WAIT;
			default:  next_state = VIC_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	wire                    do_write  = aw_held && w_held && !S_AXI_BVALID;
	wire                    do_read   = S_AXI_ARVALID && S_AXI_ARREADY;
	wire                    wr_flag   = do_write && aw_addr == OFF_FLAG;
	wire                    wr_base   = do_write && aw_addr == OFF_BASE;
	wire                    wr_mask   = do_write && aw_addr == OFF_MASK;
	wire                    rd_stat   = do_read && S_AXI_ARADDR == OFF_STATUS;
	wire integer            wr_idx    = ctrl_idx(aw_addr);
	wire integer            rd_idx    = ctrl_idx(S_AXI_ARADDR);
	wire                    wr_ok     = wr_flag || wr_base || wr_mask || aw_addr == OFF_SWTRAP || wr_idx < NSRC;
	wire                    wr_ctrl   = do_write && wr_idx < NSRC && w_strb[0];
	wire                    take_src  = take && !CPU_NMASK_O && CPU_VEC_O >= VEC_FIRST_HW
		&& CPU_VEC_O < VEC_SW_FIRST;
	wire [VEC_W-1:0]        take_slot = CPU_VEC_O - VEC_FIRST_HW;
	wire [DATA_W-1:0]       new_flag  = merge({24'h0, 1'b0, thr, 3'h0, glb_en}, w_data, w_strb);

	assign S_AXI_AWREADY = !aw_held;
	assign S_AXI_WREADY  = !w_held;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign IRQ_O         = |(status & mask);
	assign CPU_IRQ_O     = (state == VIC_WAIT);

	logic [DATA_W-1:0]      rd_word;
	logic                   rd_ok;
	always_comb begin
		rd_ok   = 1'b1;
		rd_word = '0;
		if (rd_idx < NSRC) begin
			rd_word[CTRL_REQ_BIT] = req[rd_idx];
			rd_word[CTRL_LVL_LSB +: LVL_W] = lvl[rd_idx];
		end else begin
			case (S_AXI_ARADDR)
				OFF_FLAG:   begin
					rd_word[FLG_EN_BIT] = glb_en;
					rd_word[FLG_THR_LSB +: LVL_W] = thr;
				end
				OFF_BASE:   rd_word = vbase;
				OFF_STATUS: rd_word[NUM_EV-1:0] = status;
				OFF_MASK:   rd_word[NUM_EV-1:0] = mask;
				OFF_ACCEPT: rd_word[VEC_W-1:0] = last_vec;
				OFF_SWTRAP: rd_word[VEC_W-1:0] = trap_num;
				default:    rd_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= '0;
			w_data       <= '0;
			w_strb       <= '0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= RESP_OKAY;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RRESP  <= RESP_OKAY;
			S_AXI_RDATA  <= '0;
		end else begin
			if (S_AXI_AWVALID && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_held) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (do_write) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
			end
			if (do_read) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= rd_word;
				S_AXI_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flag register, base, mask

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			glb_en <= 1'b0;
			thr    <= '0;
			vbase  <= '0;
			mask   <= '0;
		end else begin
			if (take) begin
				// Entering a handler masks further maskable requests
				glb_en <= 1'b0;
				thr    <= CPU_LVL_O;
			end else if (wr_flag) begin
				glb_en <= new_flag[FLG_EN_BIT];
				thr    <= new_flag[FLG_THR_LSB +: LVL_W];
			end
			if (wr_base) begin
				// Entries are words, so the low bits are dropped
				vbase <= merge(vbase, w_data, w_strb) & ~DATA_W'(3);
			end
			if (wr_mask) begin
				mask <= w_data[NUM_EV-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-source control registers

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			req <= '0;
			for (int i = 0; i < NSRC; i++) begin
				lvl[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NSRC; i++) begin
				if (SRC_REQ_I[i]) begin
					// Set wins over a clear in the same cycle
					req[i] <= 1'b1;
				end else if (take_src && int'(take_slot) == i) begin
					req[i] <= 1'b0;
				end else if (wr_ctrl && wr_idx == i && !w_data[CTRL_REQ_BIT]) begin
					// A one written here is ignored
					req[i] <= 1'b0;
				end
				if (wr_ctrl && wr_idx == i) begin
					lvl[i] <= w_data[CTRL_LVL_LSB +: LVL_W];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trap latch, offer, status events

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			trap_pend   <= 1'b0;
			trap_num    <= '0;
			state       <= VIC_IDLE;
			CPU_VEC_O   <= '0;
			CPU_LVL_O   <= '0;
			CPU_NMASK_O <= 1'b0;
			CPU_VADDR_O <= '0;
			last_vec    <= '0;
			status      <= '0;
		end else begin
			state <= next_state;
			if (trap_ok && !trap_pend) begin
				trap_pend <= 1'b1;
				trap_num  <= TRAP_NUM_I;
			end else if (take && CPU_NMASK_O) begin
				// Only a taken trap retires it; one that arrives during a maskable offer waits
				trap_pend <= 1'b0;
			end
			if (state == VIC_IDLE && offer) begin
				CPU_VEC_O   <= sel_vec;
				CPU_LVL_O   <= sel_lvl;
				CPU_NMASK_O <= trap_pend;
			end
			if (state == VIC_SEL) begin
				CPU_VADDR_O <= sel_addr;
			end
			if (take) begin
				last_vec <= CPU_VEC_O;
			end
			for (int e = 0; e < NUM_EV; e++) begin
				if (rd_stat) begin
					status[e] <= 1'b0;
				end
			end
			if (|SRC_REQ_I) begin
				status[EV_REQ] <= 1'b1;
			end
			if (take) begin
				status[EV_ACC] <= 1'b1;
			end
			if (trap_ok) begin
				status[EV_TRAP] <= 1'b1;
			end
		end
	end
endmodule

// [vic_pkg.sv]
// Package for the vectored interrupt control block: register map, fields, vector numbers
package vic_pkg;
	localparam int            DATA_W        = 32;
	localparam int            ADDR_W        = 12;
	localparam int            NUM_SRC       = 22;
	localparam int            LVL_W         = 3;
	localparam int            VEC_W         = 6;
	// Register byte offsets
	localparam logic [11:0]   OFF_FLAG      = 12'h000;
	localparam logic [11:0]   OFF_BASE      = 12'h004;
	localparam logic [11:0]   OFF_STATUS    = 12'h008;
	localparam logic [11:0]   OFF_MASK      = 12'h00C;
	localparam logic [11:0]   OFF_ACCEPT    = 12'h010;
	localparam logic [11:0]   OFF_SWTRAP    = 12'h014;
	localparam logic [11:0]   OFF_CTRL0     = 12'h100;
	localparam logic [11:0]   OFF_CTRL_END  = 12'h158;
	// Control register fields
	localparam int            CTRL_LVL_LSB  = 0;
	localparam int            CTRL_REQ_BIT  = 3;
	// Flag register fields
	localparam int            FLG_EN_BIT    = 0;
	localparam int            FLG_THR_LSB   = 4;
	// Vector numbering and table geometry
	localparam logic [5:0]    VEC_BRK       = 6'h00;
	localparam logic [5:0]    VEC_FIRST_HW  = 6'h0A;
	localparam logic [5:0]    VEC_SW_FIRST  = 6'h20;
	localparam int            ENTRY_SHIFT   = 2;
	localparam logic [2:0]    LVL_MAX       = 3'h7;
	localparam logic [1:0]    RESP_OKAY     = 2'h0;
	localparam logic [1:0]    RESP_SLVERR   = 2'h2;
	// Status event bits
	localparam int            EV_REQ        = 0;
	localparam int            EV_ACC        = 1;
	localparam int            EV_TRAP       = 2;
	localparam int            NUM_EV        = 3;
	typedef enum logic [1:0] {
		VIC_IDLE = 2'b00,
		VIC_SEL  = 2'b01,
		VIC_WAIT = 2'b10
	} vic_state_t;
endpackage

// [vic_cpu_model.sv]
// CPU side model: takes each offered vector after a set delay
`timescale 1ns/1ps
module vic_cpu_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       irq_i,
	input  wire logic [3:0] delay_i,
	output logic            ack_o
);
	logic [3:0] cnt;

	// One-cycle take; a slow delay lets the bench see the offer stand
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !irq_i || ack_o) begin
			cnt   <= 4'h0;
			ack_o <= 1'b0;
		end else begin
			cnt   <= cnt + 4'h1;
			ack_o <= (cnt >= delay_i);
		end
	end
endmodule

// [vic_asserts.sv]
// Concurrent checks on the vectored interrupt control ports
`timescale 1ns/1ps
module vic_asserts #(
	parameter int NSRC = vic_pkg::NUM_SRC
) (
	input wire logic                       SYS_CLK_I,
	input wire logic                       RST_N_I,
	input wire logic                       CPU_ACK_I,
	input wire logic                       CPU_IRQ_O,
	input wire logic [vic_pkg::VEC_W-1:0]  CPU_VEC_O,
	input wire logic [vic_pkg::LVL_W-1:0]  CPU_LVL_O,
	input wire logic [vic_pkg::DATA_W-1:0] CPU_VADDR_O,
	input wire logic                       CPU_NMASK_O,
	input wire logic [1:0]                 S_AXI_BRESP,
	input wire logic                       S_AXI_BVALID,
	input wire logic                       S_AXI_BREADY
);
	import vic_pkg::*;
	default clocking @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	////////////////////////////////
	vaddr_align_a: assert property (CPU_IRQ_O |-> CPU_VADDR_O[1:0] == 2'h0)
		else $error("vector address not word aligned");
	offer_hold_a: assert property (CPU_IRQ_O && !CPU_ACK_I |=> CPU_IRQ_O && $stable(CPU_VADDR_O))
		else $error("offer changed before take");
	ack_drop_a: assert property (CPU_IRQ_O && CPU_ACK_I |=> !CPU_IRQ_O)
		else $error("offer stands after take");
	brk_nmask_a: assert property (CPU_IRQ_O && CPU_VEC_O == VEC_BRK |-> CPU_NMASK_O)
		else $error("breakpoint offered as maskable");
	sw_nmask_a: assert property (CPU_IRQ_O && CPU_VEC_O >= VEC_SW_FIRST |-> CPU_NMASK_O)
		else $error("software vector offered as maskable");
	hw_range_a: assert property (CPU_IRQ_O && !CPU_NMASK_O |-> CPU_VEC_O inside {[6'h0A:6'h1F]})
		else $error("maskable vector out of range");
	lvl_live_a: assert property (CPU_IRQ_O && !CPU_NMASK_O |-> CPU_LVL_O != 3'h0)
		else $error("level zero source offered");
	bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped early");
endmodule

bind vic_core vic_asserts #(.NSRC(NSRC)) chk_u (.SYS_CLK_I, .RST_N_I, .CPU_ACK_I, .CPU_IRQ_O, .CPU_VEC_O,
	.CPU_LVL_O, .CPU_VADDR_O, .CPU_NMASK_O, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY);

// [test_vectored_interrupt_control.sv]
// Testbench for the vectored interrupt control block
`timescale 1ns/1ps
module test_vectored_interrupt_control;
	import vic_pkg::*;
	localparam logic [31:0] BASE = 32'h00002000;
	// Enable, threshold, expected offer
	localparam logic [4:0]  GT [4] = '{5'h00, 5'h1E, 5'h1A, 5'h19};
	localparam logic [5:0]  TRAPS [3] = '{6'h00, 6'h20, 6'h3F};
	logic               clk, rst_n, trq, ack, awv, wv, brd, arv, rrd, irq, nmk, irqo, awr, wrdy, bv, arr, rv;
	logic [NUM_SRC-1:0] src;
	logic [5:0]         tnum, vec;
	logic [2:0]         lvl;
	logic [11:0]        awa, ara;
	logic [31:0]        wda, va, rdat, q;
	logic [1:0]         bresp, rresp, rs;
	int                 miscompares, n_compared;

	vic_core #(.NSRC(NUM_SRC)) dut_u (.SYS_CLK_I(clk), .RST_N_I(rst_n), .SRC_REQ_I(src), .TRAP_REQ_I(trq),
		.TRAP_NUM_I(tnum), .CPU_ACK_I(ack), .CPU_IRQ_O(irq), .CPU_VEC_O(vec), .CPU_LVL_O(lvl),
		.CPU_VADDR_O(va), .CPU_NMASK_O(nmk), .IRQ_O(irqo), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wda), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd));
	vic_cpu_model cpu_u (.clk_i(clk), .rst_n_i(rst_n), .irq_i(irq), .delay_i(4'h8), .ack_o(ack));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		if (w) begin
			awa <= a;
			wda <= d;
			awv <= 1'b1;
			wv  <= 1'b1;
			brd <= 1'b1;
		end else begin
			ara <= a;
			arv <= 1'b1;
			rrd <= 1'b1;
		end
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
			if (arv && arr) arv <= 1'b0;
			n++;
		end while (!(w ? bv : rv) && n < 50);
		brd <= 1'b0;
		rrd <= 1'b0;
		q  = rdat;
		rs = w ? bresp : rresp;
		if (n >= 50) chk(32'h0, 32'h1, "bus hang");
	endtask

	task automatic wirq(input logic v);
		int n;
		n = 0;
		while (irq !== v && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk(irq, v, "offer");
	endtask

	task automatic pulse(input int i);
		@(posedge clk);
		src <= NUM_SRC'(1) << i;
		@(posedge clk);
		src <= '0;
	endtask

	task automatic give_verdict;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		chk(32'h0, 32'h1, "watchdog");
		give_verdict();
	end

	initial begin
		{rst_n, trq, awv, wv, brd, arv, rrd} = '0;
		{src, tnum, awa, ara, wda} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, OFF_FLAG, 0);
		chk(q, 32'h0, "flag reset");
		bus(1, OFF_BASE, BASE);
		chk(rs, RESP_OKAY, "write response");
		for (int i = 0; i < NUM_SRC; i++) begin
			bus(1, OFF_CTRL0 + 12'(4 * i), 32'(i % 7 + 1));
			bus(1, OFF_FLAG, 32'h1);
			pulse(i);
			wirq(1'b1);
			chk(va, BASE + 32'(4 * (10 + i)), "vector address");
			chk(vec, 32'(10 + i), "vector number");
			chk({nmk, lvl}, 32'(i % 7 + 1), "offered level");
			wirq(1'b0);
			bus(0, OFF_CTRL0 + 12'(4 * i), 0);
			chk(q, 32'(i % 7 + 1), "request after take");
		end
		$display("source vectors done");
		bus(1, OFF_CTRL0, 32'h5);
		pulse(0);
		bus(0, OFF_CTRL0, 0);
		chk(q, 32'hD, "request set");
		for (int k = 0; k < 4; k++) begin
			bus(1, OFF_FLAG, {25'h0, GT[k][3:1], 3'h0, GT[k][4]});
			repeat (6) @(posedge clk);
			chk(irq, GT[k][0], "gating");
		end
		wirq(1'b0);
		$display("gating done");
		bus(1, OFF_FLAG, 32'h1);
		bus(1, OFF_CTRL0 + 12'h4, 32'h0);
		pulse(1);
		repeat (6) @(posedge clk);
		chk(irq, 1'b0, "level zero");
		bus(0, OFF_CTRL0 + 12'h4, 0);
		chk(q, 32'h8, "pending");
		bus(1, OFF_CTRL0 + 12'h4, 32'h0);
		bus(0, OFF_CTRL0 + 12'h4, 0);
		chk(q, 32'h0, "software clear");
		$display("clear done");
		bus(1, OFF_FLAG, 32'h70);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			trq  <= 1'b1;
			tnum <= TRAPS[k];
			@(posedge clk);
			trq <= 1'b0;
			wirq(1'b1);
			chk(va, BASE + 32'(4 * TRAPS[k]), "trap address");
			chk(nmk, 1'b1, "trap class");
			chk(lvl, 32'(LVL_MAX), "trap level");
			wirq(1'b0);
		end
		bus(0, OFF_ACCEPT, 0);
		chk(q, 32'h3F, "accepted vector");
		// Trap raised while a maskable offer stands must survive its take
		bus(1, OFF_FLAG, 32'h1);
		bus(1, OFF_CTRL0, 32'h3);
		pulse(0);
		wirq(1'b1);
		@(posedge clk);
		trq  <= 1'b1;
		tnum <= TRAPS[1];
		@(posedge clk);
		trq <= 1'b0;
		wirq(1'b0);
		wirq(1'b1);
		chk(vec, 32'(TRAPS[1]), "trap after source");
		chk(nmk, 1'b1, "late trap class");
		wirq(1'b0);
		bus(0, OFF_CTRL0, 0);
		chk(q, 32'h3, "source taken");
		$display("traps done");
		bus(0, OFF_STATUS, 0);
		bus(1, OFF_MASK, 32'h0);
		pulse(1);
		@(posedge clk);
		chk(irqo, 1'b0, "masked");
		bus(1, OFF_MASK, 32'h1);
		chk(irqo, 1'b1, "unmasked");
		bus(0, OFF_STATUS, 0);
		chk(q, 32'h1, "status");
		@(posedge clk);
		chk(irqo, 1'b0, "status cleared");
		$display("interrupt line done");
		bus(0, 12'h800, 0);
		chk(rs, RESP_SLVERR, "unmapped");
		bus(1, 12'h800, 32'h1);
		chk(rs, RESP_SLVERR, "unmapped write");
		$display("unmapped done");
		give_verdict();
	end
endmodule
